// ---- rtl/tlc_pkg.sv ----
// Purpose: Shared constants and types for the line interface control block
// Assumes: 8-bit register data, 16-bit register addresses
// Notes: Addresses are those of the first port; others add a port stride
package tlc_pkg;

  // Port spacing and register addresses of the first port
  localparam logic [15:0] TLC_PORT_STRIDE = 16'h0200;
  localparam logic [15:0] TLC_ADDR_TXRX_CTRL = 16'h1000;
  localparam logic [15:0] TLC_ADDR_TX_SHAPE = 16'h1001;
  localparam logic [15:0] TLC_ADDR_MAINT = 16'h1002;
  localparam logic [15:0] TLC_ADDR_LIVE = 16'h1003;
  localparam logic [15:0] TLC_ADDR_MASK = 16'h1004;
  localparam logic [15:0] TLC_ADDR_LATCHED = 16'h1005;
  localparam logic [15:0] TLC_ADDR_LEVEL = 16'h1006;
  localparam logic [15:0] TLC_ADDR_RX_IMP = 16'h1007;
  localparam logic [15:0] TLC_ADDR_RX_CTRL = 16'h1008;
  localparam logic [15:0] TLC_ADDR_CENTER_A = 16'h1229;
  localparam logic [15:0] TLC_ADDR_CENTER_B = 16'h122d;

  // Field positions, transmit/receive control
  localparam int TLC_MODE_LSB = 0;
  localparam int TLC_RX_PROTECT_BIT = 2;
  localparam int TLC_TX_HIZ_BIT = 3;
  localparam int TLC_AMI_BIT = 4;
  localparam int TLC_JA_TX_BIT = 5;
  // Field positions, transmit shape and impedance
  localparam int TLC_LBO_LSB = 0;
  localparam int TLC_TX_TERM_LSB = 3;
  localparam int TLC_TX_SYNC_BIT = 7;
  // Field positions, maintenance control
  localparam int TLC_TX_PDN_BIT = 0;
  localparam int TLC_ALL_ONES_BIT = 1;
  localparam int TLC_AUTO_AIS_BIT = 2;
  // Field positions, receive impedance and receive control
  localparam int TLC_RX_IMP_LSB = 0;
  localparam int TLC_RX_TERM_EN_BIT = 2;
  localparam int TLC_RX_SENS_LSB = 0;
  localparam int TLC_RX_SYNC_BIT = 7;

  // Reset values
  localparam logic [7:0] TLC_RST_TXRX_CTRL = 8'h00;
  localparam logic [7:0] TLC_RST_TX_SHAPE = 8'h00;
  localparam logic [7:0] TLC_RST_MAINT = 8'h00;
  localparam logic [7:0] TLC_RST_MASK = 8'h00;
  localparam logic [7:0] TLC_RST_RX_IMP = 8'h00;
  localparam logic [7:0] TLC_RST_RX_CTRL = 8'h00;
  localparam logic [7:0] TLC_RST_CENTER = 8'h00;

  // Line build-out codes without open-circuit detection
  localparam logic [2:0] TLC_LBO_CSU_LO = 3'h5;
  localparam logic [2:0] TLC_LBO_CSU_HI = 3'h7;

  // Timing and loss criteria
  localparam logic [3:0] TLC_OVERSAMPLE_LAST = 4'hf;
  localparam logic [3:0] TLC_SAMPLE_PHASE = 4'h8;
  localparam logic [7:0] TLC_LOS_WINDOW_BITS = 8'hc0;
  localparam logic [7:0] TLC_LOS_MIN_ONES = 8'h18;
  localparam logic [6:0] TLC_LOS_MAX_ZERO_RUN = 7'h64;
  localparam logic [5:0] TLC_LOS_HYST_DB = 6'h03;
  // Sensitivity in dB of cable loss per code
  localparam logic [5:0] TLC_SENS_DB0 = 6'h0c;
  localparam logic [5:0] TLC_SENS_DB1 = 6'h12;
  localparam logic [5:0] TLC_SENS_DB2 = 6'h1e;
  localparam logic [5:0] TLC_SENS_DB3 = 6'h24;

  typedef enum logic [1:0] {
    TLC_MODE_E1 = 2'b00,
    TLC_MODE_T1 = 2'b01,
    TLC_MODE_J1 = 2'b10
  } tlc_mode_type;

  typedef enum logic [1:0] {
    TLC_SYM_ZERO = 2'b00,
    TLC_SYM_MARK = 2'b01,
    TLC_SYM_BIP = 2'b10,
    TLC_SYM_VIOL = 2'b11
  } tlc_sym_type;

  typedef enum logic {
    TLC_LOS_CLEAR = 1'b0,
    TLC_LOS_ACTIVE = 1'b1
  } tlc_los_type;

  // Live driver and receiver conditions, bit 2 down to bit 0
  typedef struct packed {
    logic shortLive;
    logic openLive;
    logic lossLive;
  } tlc_status_type;

endpackage : tlc_pkg

// ---- rtl/tlc_line_interface.sv ----
// Purpose: Control and status logic of one line interface port
// Assumes: Register port and line strobes synchronous to clk (100 MHz)
// Notes: mclkX16Strobe is the 16x line-rate tick from the clock multiplier
// Notes on behaviour
// - Port n registers sit at first-port address plus (n-1) times 0x200.
// - Tx data coded HDB3, B8ZS or AMI; attenuator path optional.
// - Release pin and per-port bit each three-state the driver.
// - Per-port config selects pulse shape and tx termination.
// - Sync-clock bit replaces line code by a 2.048MHz square wave.
// - Power-down bit turns transmitter off, floats both outputs.
// - All-ones bit sends ones on master timing, ignoring framer.
// - Auto all-ones bit sends ones while receiver is in loss.
// - Live status bit 2 shows short-circuit limiter active.
// - Latches capture short and open; unmasked bits raise interrupt.
// - Live status bit 1 shows open circuit on either output.
// - No open-circuit report in build-out settings 5 to 7.
// - Receive termination comes out of reset open.
// - Receiver oversamples 16x line rate to recover clock and data.
// - In loss the recovered clock comes from master timing.
// - Received level is reported in 2.5dB steps in a four-bit field.
// - Rx control bit 7 selects square-wave sync clock reception.
// - Loss is declared 3dB below programmed sensitivity.
// - Loss exits only with signal level at programmed sensitivity for a whole window.
// - Low release floats drivers; with protect bit, opens rx term.
// - T1/J1 exit needs 24 ones in 192 bits, no 100-zero run.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module tlc_line_interface
  import tlc_pkg::*;
#(
  parameter int PORT_INDEX = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // Global protection pin
  input wire logic globalLineDriverRelease,
  // Framer transmit data
  input wire logic txBitStrobe,
  input wire logic txData,
  // Master timing
  input wire logic mclkX16Strobe,
  // Transmit line and analog front end
  input wire logic txShortDetect,
  input wire logic txOpenDetect,
  output logic txLinePos,
  output logic txLineNeg,
  output logic txLineOe,
  output logic txPowerDown,
  output logic [2:0] txTermSelect,
  output logic [2:0] lineBuildOutSelect,
  output logic txJitterPath,
  output logic [7:0] txCenterA,
  output logic [7:0] txCenterB,
  // Receive line and analog front end
  input wire logic rxLinePos,
  input wire logic rxLineNeg,
  input wire logic [5:0] rxAttenDb,
  output logic rxTermEnable,
  output logic [1:0] rxImpedanceField,
  output logic rxSyncMode,
  output logic recoveredClockOut,
  output logic recoveredData,
  output logic recoveredStrobe,
  output logic carrierLossCondition,
  output logic lineIrq
);

  localparam logic [15:0] PORT_OFS = 16'((PORT_INDEX - 1) * 512);

  // Sensitivity code to dB of cable loss
  function automatic logic [5:0] sensDb(input logic [1:0] code);
    case (code)
      2'b00: sensDb = TLC_SENS_DB0;
      2'b01: sensDb = TLC_SENS_DB1;
      2'b10: sensDb = TLC_SENS_DB2;
      default: sensDb = TLC_SENS_DB3;
    endcase
  endfunction : sensDb

  // dB of attenuation to 2.5dB level steps, saturating at 15
  function automatic logic [3:0] dbToLevel(input logic [5:0] db);
    logic [7:0] steps;
    steps = 8'({1'b0, db, 1'b0} / 8'h05);
    dbToLevel = (steps > 8'h0f) ? 4'hf : steps[3:0];
  endfunction : dbToLevel

  logic [7:0] txrxCtrl;
  logic [7:0] txShape;
  logic [7:0] maint;
  logic [7:0] irqMask;
  logic [7:0] rxImp;
  logic [7:0] rxCtrl;
  logic [7:0] latched;
  logic [7:0] next_latched;
  tlc_status_type live;
  tlc_status_type liveDly;
  tlc_los_type losState;
  tlc_los_type next_losState;

  // Address decode relative to this port's bank
  wire logic [15:0] relAddr = regAddr - PORT_OFS;
  wire logic selTxrx = relAddr == TLC_ADDR_TXRX_CTRL;
  wire logic selShape = relAddr == TLC_ADDR_TX_SHAPE;
  wire logic selMaint = relAddr == TLC_ADDR_MAINT;
  wire logic selLive = relAddr == TLC_ADDR_LIVE;
  wire logic selMask = relAddr == TLC_ADDR_MASK;
  wire logic selLatched = relAddr == TLC_ADDR_LATCHED;
  wire logic selLevel = relAddr == TLC_ADDR_LEVEL;
  wire logic selRxImp = relAddr == TLC_ADDR_RX_IMP;
  wire logic selRxCtrl = relAddr == TLC_ADDR_RX_CTRL;
  wire logic selCenterA = relAddr == TLC_ADDR_CENTER_A;
  wire logic selCenterB = relAddr == TLC_ADDR_CENTER_B;

  // Configuration fields
  wire tlc_mode_type lineMode = tlc_mode_type'(txrxCtrl[TLC_MODE_LSB +: 2]);
  wire logic rxProtect = txrxCtrl[TLC_RX_PROTECT_BIT];
  wire logic txHiz = txrxCtrl[TLC_TX_HIZ_BIT];
  wire logic amiOnly = txrxCtrl[TLC_AMI_BIT];
  wire logic txSyncClock = txShape[TLC_TX_SYNC_BIT];
  wire logic txPdn = maint[TLC_TX_PDN_BIT];
  wire logic allOnes = maint[TLC_ALL_ONES_BIT];
  wire logic autoAis = maint[TLC_AUTO_AIS_BIT];
  wire logic rxTermOn = rxImp[TLC_RX_TERM_EN_BIT];
  wire logic [1:0] rxSens = rxCtrl[TLC_RX_SENS_LSB +: 2];
  wire logic isE1 = lineMode == TLC_MODE_E1;

  // Configuration to the analog front end
  assign lineBuildOutSelect = txShape[TLC_LBO_LSB +: 3];
  assign txTermSelect = txShape[TLC_TX_TERM_LSB +: 3];
  assign txJitterPath = txrxCtrl[TLC_JA_TX_BIT];
  assign rxImpedanceField = rxImp[TLC_RX_IMP_LSB +: 2];
  assign rxSyncMode = rxCtrl[TLC_RX_SYNC_BIT];
  assign txPowerDown = txPdn;
  // Pin release acts without a clock edge for fast protection switching
  assign txLineOe = globalLineDriverRelease & ~txHiz & ~txPdn;
  assign rxTermEnable = rxTermOn & ~(rxProtect & ~globalLineDriverRelease);

  // Register writes; latched bits clear by writing one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txrxCtrl <= TLC_RST_TXRX_CTRL;
      txShape <= TLC_RST_TX_SHAPE;
      maint <= TLC_RST_MAINT;
      irqMask <= TLC_RST_MASK;
      rxImp <= TLC_RST_RX_IMP;
      rxCtrl <= TLC_RST_RX_CTRL;
      txCenterA <= TLC_RST_CENTER;
      txCenterB <= TLC_RST_CENTER;
    end else if (regWr) begin
      if (selTxrx) txrxCtrl <= regWrData;
      if (selShape) txShape <= regWrData;
      if (selMaint) maint <= regWrData;
      if (selMask) irqMask <= regWrData;
      if (selRxImp) rxImp <= regWrData;
      if (selRxCtrl) rxCtrl <= regWrData;
      if (selCenterA) txCenterA <= regWrData;
      if (selCenterB) txCenterB <= regWrData;
    end
  end

  // Live conditions; open detection is blind in CSU build-outs
  wire logic lboCsu = lineBuildOutSelect >= TLC_LBO_CSU_LO &&
                      lineBuildOutSelect <= TLC_LBO_CSU_HI;
  assign live.shortLive = txShortDetect & txLineOe;
  assign live.openLive = txOpenDetect & txLineOe & ~lboCsu;
  assign live.lossLive = losState == TLC_LOS_ACTIVE;

  // Rising live condition sets its latch; a set beats a same-cycle clear
  wire logic [7:0] latchSet = {5'h00, live & ~liveDly};
  wire logic [7:0] latchClr = (regWr && selLatched) ? regWrData : 8'h00;
  assign next_latched = (latched & ~latchClr) | latchSet;
  assign lineIrq = |(latched & irqMask);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latched <= 8'h00;
      liveDly <= '0;
    end else begin
      latched <= next_latched;
      liveDly <= live;
    end
  end

  // Read data stands for the cycle after the strobe only
  wire logic [3:0] rxLevel = dbToLevel(rxAttenDb);
  wire logic [7:0] rdMux =
    selTxrx ? txrxCtrl :
    selShape ? txShape :
    selMaint ? maint :
    selLive ? {5'h00, live} :
    selMask ? irqMask :
    selLatched ? latched :
    selLevel ? {4'h0, rxLevel} :
    selRxImp ? rxImp :
    selRxCtrl ? rxCtrl :
    selCenterA ? txCenterA :
    selCenterB ? txCenterB : 8'h00;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) regRdData <= 8'h00;
    else regRdData <= regRd ? rdMux : 8'h00;
  end

  // Master timing: one line bit every 16 multiplier ticks
  logic [3:0] mclkPhase;
  wire logic mclkBitTick = mclkX16Strobe && mclkPhase == TLC_OVERSAMPLE_LAST;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) mclkPhase <= 4'h0;
    else if (mclkX16Strobe) mclkPhase <= mclkPhase + 4'h1;
  end

  // Transmit source: all ones on master timing replaces framer data
  wire logic sendOnes = allOnes | (autoAis & live.lossLive);
  wire logic bitTick = sendOnes ? mclkBitTick : txBitStrobe;
  wire logic inBit = sendOnes | txData;
  wire tlc_sym_type inSym = inBit ? TLC_SYM_MARK : TLC_SYM_ZERO;

  // Eight-bit look-ahead so zero runs can be rewritten before they leave
  tlc_sym_type pipe [0:7];
  tlc_sym_type next_pipe [0:7];
  logic markOdd;
  logic next_markOdd;
  logic b8zsZeros;
  logic hdb3Zeros;

  always_comb begin
    next_pipe[0] = inSym;
    for (int i = 1; i < 8; i++) begin
      next_pipe[i] = pipe[i - 1];
    end
    b8zsZeros = 1'b1;
    hdb3Zeros = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (next_pipe[i] != TLC_SYM_ZERO) b8zsZeros = 1'b0;
      if (i < 4 && next_pipe[i] != TLC_SYM_ZERO) hdb3Zeros = 1'b0;
    end
    next_markOdd = markOdd ^ inBit;
    if (!amiOnly && !isE1 && b8zsZeros) begin
      // Oldest first: 000VB0VB
      next_pipe[4] = TLC_SYM_VIOL;
      next_pipe[3] = TLC_SYM_BIP;
      next_pipe[1] = TLC_SYM_VIOL;
      next_pipe[0] = TLC_SYM_BIP;
    end else if (!amiOnly && isE1 && hdb3Zeros) begin
      // Odd pulse count since last violation: 000V, else B00V
      next_pipe[0] = TLC_SYM_VIOL;
      if (!markOdd) next_pipe[3] = TLC_SYM_BIP;
      next_markOdd = 1'b0;
    end
  end

  // Output polarity: marks alternate, violations repeat the last polarity
  logic lastPos;
  wire tlc_sym_type outSym = pipe[7];
  wire logic outPulse = outSym != TLC_SYM_ZERO;
  wire logic outPos = (outSym == TLC_SYM_VIOL) ? lastPos : ~lastPos;
  // Square wave at line rate from the master timing phase
  wire logic sqWave = mclkPhase[3];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 8; i++) pipe[i] <= TLC_SYM_ZERO;
      markOdd <= 1'b0;
      lastPos <= 1'b0;
    end else if (bitTick) begin
      pipe <= next_pipe;
      markOdd <= next_markOdd;
      if (outPulse) lastPos <= outPos;
    end
  end

  // Line drive; held at zero while powered down
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txLinePos <= 1'b0;
      txLineNeg <= 1'b0;
    end else if (txPdn) begin
      txLinePos <= 1'b0;
      txLineNeg <= 1'b0;
    end else if (txSyncClock) begin
      txLinePos <= sqWave;
      txLineNeg <= ~sqWave;
    end else if (bitTick) begin
      txLinePos <= outPulse & outPos;
      txLineNeg <= outPulse & ~outPos;
    end
  end

  // Oversampling clock recovery; phase restarts at each pulse edge
  logic rxPulseDly;
  logic rxPulseSeen;
  logic [3:0] rxPhase;
  wire logic rxPulse = rxLinePos | rxLineNeg;
  wire logic rxEdge = rxPulse & ~rxPulseDly;
  wire logic rxSample = mclkX16Strobe && rxPhase == TLC_SAMPLE_PHASE;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxPulseDly <= 1'b0;
      rxPulseSeen <= 1'b0;
      rxPhase <= 4'h0;
    end else if (mclkX16Strobe) begin
      rxPulseDly <= rxPulse;
      rxPhase <= rxEdge ? 4'h1 : rxPhase + 4'h1;
      rxPulseSeen <= rxSample ? rxPulse : (rxPulseSeen | rxPulse);
    end
  end

  // Recovered data, strobe and clock; master phase during loss
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      recoveredData <= 1'b0;
      recoveredStrobe <= 1'b0;
      recoveredClockOut <= 1'b0;
    end else begin
      recoveredStrobe <= rxSample;
      if (rxSample) recoveredData <= rxSyncMode | rxPulseSeen | rxPulse;
      recoveredClockOut <= live.lossLive ? ~mclkPhase[3]
                                         : (rxPhase < TLC_SAMPLE_PHASE);
    end
  end

  // Loss thresholds with hysteresis between declare and clear
  wire logic [5:0] sensLimit = sensDb(rxSens);
  wire logic lowLevel = rxAttenDb >= sensLimit + TLC_LOS_HYST_DB;
  wire logic goodLevel = rxAttenDb <= sensLimit;
  wire logic rxOne = rxSample & (rxPulseSeen | rxPulse);

  logic [7:0] lowCnt;
  logic [7:0] winCnt;
  logic [7:0] onesCnt;
  logic [6:0] zeroRun;
  logic zeroFail;
  logic levelFail;
  wire logic winEnd = mclkBitTick && winCnt == TLC_LOS_WINDOW_BITS - 8'h01;
  wire logic lowDone = lowCnt == TLC_LOS_WINDOW_BITS;
  wire logic t1Pass = onesCnt >= TLC_LOS_MIN_ONES && !zeroFail;
  wire logic exitOk = !levelFail && (isE1 || t1Pass);

  // Window statistics, counted on master bit timing; ones counted on recovered samples
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lowCnt <= 8'h00;
      winCnt <= 8'h00;
      onesCnt <= 8'h00;
      zeroRun <= 7'h00;
      zeroFail <= 1'b0;
      levelFail <= 1'b0;
    end else begin
      if (!lowLevel) lowCnt <= 8'h00;
      else if (mclkBitTick && !lowDone) lowCnt <= lowCnt + 8'h01;
      if (winEnd) begin
        winCnt <= 8'h00;
        onesCnt <= 8'h00;
        zeroFail <= 1'b0;
        levelFail <= 1'b0;
      end else begin
        if (mclkBitTick) winCnt <= winCnt + 8'h01;
        if (rxOne && onesCnt != 8'hff) onesCnt <= onesCnt + 8'h01;
        if (zeroRun >= TLC_LOS_MAX_ZERO_RUN) zeroFail <= 1'b1;
        if (mclkBitTick && !goodLevel) levelFail <= 1'b1;
      end
      if (rxOne) zeroRun <= 7'h00;
      else if (mclkBitTick && zeroRun != 7'h7f) zeroRun <= zeroRun + 7'h01;
    end
  end

  // Loss state machine
  always_comb begin
    next_losState = losState;
    case (losState)
      // Declare on a master tick so loss always moves on line timing
      TLC_LOS_CLEAR:
        if (lowDone && mclkX16Strobe) next_losState = TLC_LOS_ACTIVE;
      TLC_LOS_ACTIVE: if (winEnd && exitOk) next_losState = TLC_LOS_CLEAR;
      default: next_losState = TLC_LOS_CLEAR;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) losState <= TLC_LOS_CLEAR;
    else losState <= next_losState;
  end

  assign carrierLossCondition = live.lossLive;

endmodule : tlc_line_interface

// ---- sim/tlc_line_monitor.sv ----
// Purpose: Port-level checks of one line interface port
// Assumes: One clock domain, reset active low
// Notes: Register contents are left to the bench
`timescale 1ns/1ps
module tlc_line_monitor
  import tlc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Watched ports
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic globalLineDriverRelease,
  input wire logic mclkX16Strobe,
  input wire logic txShortDetect,
  input wire logic txOpenDetect,
  input wire logic txLinePos,
  input wire logic txLineNeg,
  input wire logic txLineOe,
  input wire logic txPowerDown,
  input wire logic recoveredStrobe,
  input wire logic carrierLossCondition,
  input wire logic lineIrq
);
  // Shared clock and disable
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_release; !globalLineDriverRelease |-> !txLineOe; endproperty
  a_release: assert property (p_release)
    else $error("oe while released");
  property p_pdn_oe; txPowerDown |-> !txLineOe; endproperty
  a_pdn_oe: assert property (p_pdn_oe)
    else $error("oe in power-down");
  property p_pdn_line;
    $past(txPowerDown) |-> !txLinePos && !txLineNeg;
  endproperty
  a_pdn_line: assert property (p_pdn_line)
    else $error("pulse in power-down");
  property p_rd_idle; !$past(regRd) |-> regRdData == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("stray read data");
  property p_one_mark; !(txLinePos && txLineNeg); endproperty
  a_one_mark: assert property (p_one_mark)
    else $error("both polarities");
  property p_bit_once; recoveredStrobe |=> !recoveredStrobe; endproperty
  a_bit_once: assert property (p_bit_once)
    else $error("long recovered strobe");
  property p_bit_tick; recoveredStrobe |-> $past(mclkX16Strobe); endproperty
  a_bit_tick: assert property (p_bit_tick)
    else $error("strobe off tick");
  property p_irq_cause;
    $rose(lineIrq) |-> $past(regWr) || $past(txShortDetect) ||
      $past(txOpenDetect) || $past(carrierLossCondition);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq without cause");
  property p_loss_tick;
    $changed(carrierLossCondition) |-> $past(mclkX16Strobe);
  endproperty
  a_loss_tick: assert property (p_loss_tick)
    else $error("loss off tick");
endmodule : tlc_line_monitor

bind tlc_line_interface tlc_line_monitor tlc_line_monitor_i (.*);

// ---- sim/tlc_line_model.sv ----
// Purpose: Framer and line stand-in for one port
// Assumes: Master 16x tick every second cycle, bit period 32 cycles
// Notes: Line marks alternate and fill the first half bit
`timescale 1ns/1ps
module tlc_line_model
  import tlc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Data choice from the bench
  input wire logic txOnes,
  input wire logic rxOnes,
  // Towards the port
  output logic mclkX16Strobe,
  output logic txBitStrobe,
  output logic txData,
  output logic rxLinePos,
  output logic rxLineNeg
);
  logic [4:0] slot;
  logic polarity;
  // Free-running bit timer; polarity flips per bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slot <= 5'h00;
      polarity <= 1'b0;
    end else begin
      slot <= slot + 5'h01;
      polarity <= polarity ^ (slot == 5'h1f);
    end
  end
  // Framer ticks ride on master timing
  assign mclkX16Strobe = slot[0];
  assign txBitStrobe = (slot == 5'h1f);
  assign txData = txOnes;
  // No mark means both lines at rest
  assign rxLinePos = rxOnes & ~slot[4] & polarity;
  assign rxLineNeg = rxOnes & ~slot[4] & ~polarity;
endmodule : tlc_line_model

// ---- sim/tb.sv ----
// Purpose: Self-checking bench of the second port
// Assumes: Port index 2, so its bank sits one stride up
// Notes: Loss waits span whole 192-bit windows
`timescale 1ns/1ps
module tb
  import tlc_pkg::*;
  ;
  logic clk = 1'b0, rst_b = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0, regRd = 1'b0;
  logic globalLineDriverRelease = 1'b1;
  logic txShortDetect = 1'b0, txOpenDetect = 1'b0;
  logic [5:0] rxAttenDb = 6'h00;
  logic txOnes = 1'b0, rxOnes = 1'b1;
  logic [7:0] regRdData, txCenterA, txCenterB;
  logic [2:0] txTermSelect, lineBuildOutSelect;
  logic [1:0] rxImpedanceField;
  logic txLinePos, txLineNeg, txLineOe, txPowerDown, txJitterPath;
  logic rxTermEnable, rxSyncMode, recoveredClockOut, recoveredData;
  logic recoveredStrobe, carrierLossCondition, lineIrq;
  logic mclkX16Strobe, txBitStrobe, txData, rxLinePos, rxLineNeg;
  int err_total = 0;
  int checks_done = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  tlc_line_interface #(.PORT_INDEX(2)) tlc_line_interface_i (.*);
  tlc_line_model tlc_line_model_i (.*);

  task automatic print_verdict();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(string what, logic [7:0] got, logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Bus cycles at first-port addresses plus one stride
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge clk);
    regAddr <= a + TLC_PORT_STRIDE;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(string what, logic [15:0] a, logic [7:0] exp);
    @(posedge clk);
    regAddr <= a + TLC_PORT_STRIDE;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(what, regRdData, exp);
  endtask : rd
  // Marks per 16 bits after the pipe drains
  task automatic marks(logic [7:0] expPos, logic [7:0] expNeg);
    logic [7:0] p;
    logic [7:0] q;
    p = 8'h00;
    q = 8'h00;
    repeat (9) @(posedge clk iff txBitStrobe);
    repeat (16) begin
      @(posedge clk iff txBitStrobe);
      #1;
      p = p + {7'h00, txLinePos};
      q = q + {7'h00, txLineNeg};
    end
    chk("pos marks", p, expPos);
    chk("neg marks", q, expNeg);
  endtask : marks
  // Eight master ticks flip bit 3 of the master phase
  task automatic flips(string what, logic sel);
    logic s;
    @(posedge clk);
    #1 s = sel ? recoveredClockOut : txLinePos;
    repeat (16) @(posedge clk);
    #1 chk(what, sel ? recoveredClockOut : txLinePos, !s);
  endtask : flips
  task automatic wait_loss(logic lvl, int limit);
    for (int k = 0; k < limit && carrierLossCondition !== lvl; k++)
      @(posedge clk);
    #1 chk("loss", carrierLossCondition, lvl);
  endtask : wait_loss

  task automatic t_reset();
    chk("rx term", rxTermEnable, 1'b0);
    chk("oe", txLineOe, 1'b1);
    rd("txrx", TLC_ADDR_TXRX_CTRL, TLC_RST_TXRX_CTRL);
    rd("maint", TLC_ADDR_MAINT, TLC_RST_MAINT);
    rd("mask", TLC_ADDR_MASK, TLC_RST_MASK);
    rd("rx imp", TLC_ADDR_RX_IMP, TLC_RST_RX_IMP);
    rd("live", TLC_ADDR_LIVE, 8'h00);
  endtask : t_reset
  // Own bank only; first port's address and a gap stay dark
  task automatic t_bank();
    wr(TLC_ADDR_CENTER_A, 8'hf8);
    wr(TLC_ADDR_CENTER_B, 8'h09);
    wr(TLC_ADDR_CENTER_A - TLC_PORT_STRIDE, 8'h55);
    rd("ctr a", TLC_ADDR_CENTER_A, 8'hf8);
    rd("ctr b", TLC_ADDR_CENTER_B, 8'h09);
    rd("port1", TLC_ADDR_CENTER_A - TLC_PORT_STRIDE, 8'h00);
    rd("gap", TLC_ADDR_RX_CTRL + 16'h0001, 8'h00);
    chk("ctr a out", txCenterA, 8'hf8);
    chk("ctr b out", txCenterB, 8'h09);
  endtask : t_bank
  task automatic t_driver();
    wr(TLC_ADDR_TXRX_CTRL, 8'h28);
    chk("oe hiz", txLineOe, 1'b0);
    chk("ja", txJitterPath, 1'b1);
    wr(TLC_ADDR_TXRX_CTRL, 8'h00);
    globalLineDriverRelease <= 1'b0;
    @(posedge clk);
    #1 chk("oe rel", txLineOe, 1'b0);
    globalLineDriverRelease <= 1'b1;
    wr(TLC_ADDR_MAINT, 8'h01);
    chk("pdn", txPowerDown, 1'b1);
    chk("oe pdn", txLineOe, 1'b0);
    wr(TLC_ADDR_MAINT, 8'h00);
    wr(TLC_ADDR_TX_SHAPE, 8'h2a);
    chk("term", txTermSelect, 3'h5);
    chk("lbo", lineBuildOutSelect, 3'h2);
  endtask : t_driver
  // Short and open detectors, latches, mask, clear by writing ones
  task automatic t_status();
    wr(TLC_ADDR_MASK, 8'h04);
    txShortDetect <= 1'b1;
    rd("live s", TLC_ADDR_LIVE, 8'h04);
    rd("latch s", TLC_ADDR_LATCHED, 8'h04);
    chk("irq on", lineIrq, 1'b1);
    txShortDetect <= 1'b0;
    wr(TLC_ADDR_LATCHED, 8'h04);
    chk("irq off", lineIrq, 1'b0);
    wr(TLC_ADDR_TX_SHAPE, 8'h07);
    txOpenDetect <= 1'b1;
    rd("live csu", TLC_ADDR_LIVE, 8'h00);
    rd("latch csu", TLC_ADDR_LATCHED, 8'h00);
    wr(TLC_ADDR_TX_SHAPE, 8'h04);
    rd("live o", TLC_ADDR_LIVE, 8'h02);
    chk("irq mask", lineIrq, 1'b0);
    txOpenDetect <= 1'b0;
    wr(TLC_ADDR_LATCHED, 8'h02);
    wr(TLC_ADDR_TX_SHAPE, 8'h00);
  endtask : t_status
  task automatic t_rx();
    wr(TLC_ADDR_RX_IMP, 8'h05);
    chk("imp", rxImpedanceField, 2'h1);
    chk("term on", rxTermEnable, 1'b1);
    wr(TLC_ADDR_TXRX_CTRL, 8'h04);
    globalLineDriverRelease <= 1'b0;
    @(posedge clk);
    #1 chk("term prot", rxTermEnable, 1'b0);
    globalLineDriverRelease <= 1'b1;
    wr(TLC_ADDR_RX_CTRL, 8'h80);
    chk("rx sync", rxSyncMode, 1'b1);
    wr(TLC_ADDR_RX_CTRL, 8'h00);
    rxAttenDb <= 6'd25;
    rd("level", TLC_ADDR_LEVEL, 8'h0a);
    rxAttenDb <= 6'd40;
    rd("level max", TLC_ADDR_LEVEL, 8'h0f);
    rxAttenDb <= 6'd0;
  endtask : t_rx
  // Line codes seen as marks per 16 bits
  task automatic t_code();
    wr(TLC_ADDR_TXRX_CTRL, 8'h10);
    txOnes <= 1'b1;
    marks(8'd8, 8'd8);
    wr(TLC_ADDR_MAINT, 8'h01);
    marks(8'd0, 8'd0);
    wr(TLC_ADDR_MAINT, 8'h02);
    txOnes <= 1'b0;
    marks(8'd8, 8'd8);
    wr(TLC_ADDR_MAINT, 8'h00);
    marks(8'd0, 8'd0);
    wr(TLC_ADDR_TXRX_CTRL, 8'h02);
    marks(8'd4, 8'd4);
    wr(TLC_ADDR_TXRX_CTRL, 8'h00);
    marks(8'd4, 8'd4);
    wr(TLC_ADDR_TX_SHAPE, 8'h80);
    flips("sync pos", 1'b0);
    chk("sync neg", txLineNeg, !txLinePos);
    wr(TLC_ADDR_TX_SHAPE, 8'h00);
  endtask : t_code
  // Sensitivity 12 dB: declare at 15, clear needs 12 or better
  task automatic t_loss();
    rxAttenDb <= 6'd14;
    repeat (6400) @(posedge clk);
    #1 chk("no loss", carrierLossCondition, 1'b0);
    rxAttenDb <= 6'd15;
    wait_loss(1'b1, 7000);
    rd("live l", TLC_ADDR_LIVE, 8'h01);
    flips("rclk", 1'b1);
    wr(TLC_ADDR_TXRX_CTRL, 8'h10);
    wr(TLC_ADDR_MAINT, 8'h04);
    marks(8'd8, 8'd8);
    wr(TLC_ADDR_MAINT, 8'h00);
    rxAttenDb <= 6'd13;
    repeat (13000) @(posedge clk);
    #1 chk("hyst", carrierLossCondition, 1'b1);
    wr(TLC_ADDR_TXRX_CTRL, 8'h01);
    rxAttenDb <= 6'd10;
    rxOnes <= 1'b0;
    repeat (13000) @(posedge clk);
    #1 chk("zeros", carrierLossCondition, 1'b1);
    chk("rx data", recoveredData, 1'b0);
    rxOnes <= 1'b1;
    wait_loss(1'b0, 13000);
  endtask : t_loss

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_bank();
    t_driver();
    t_status();
    t_rx();
    t_code();
    t_loss();
    print_verdict();
  end
  // Watchdog well past the expected run
  initial begin
    #950000;
    err_total++;
    print_verdict();
  end
endmodule : tb
